// file: design/bjdc_axis_time.sv
// Per-axis command deceleration time from mode and time constant
`timescale 1ns/1ns
module bjdc_axis_time (
    input wire logic [1:0] mode,
    input wire logic [bjdc_pkg::TC_W-1:0] time_const,
    output logic [bjdc_pkg::DUR_W-1:0] ticks
);

    // Linear deceleration ends in one time constant; exponential tail is cut off
    always_comb begin
        ticks = bjdc_pkg::DUR_W'(time_const);
        if (mode == bjdc_pkg::BJDC_ACC_EXP) begin
            ticks = bjdc_pkg::DUR_W'(time_const) *
                    bjdc_pkg::DUR_W'(bjdc_pkg::EXP_DECEL_MULT);
        end
    end

endmodule

// file: design/bjdc_pkg.sv
// Package for the block-joint deceleration check: map, fields, types and timing
package bjdc_pkg;

    // Number of servo axes that take part in interpolation
    localparam int unsigned NUM_AXES = 4;
    localparam int unsigned WIDTH_W = 16;
    localparam int unsigned TC_W = 16;
    localparam int unsigned DUR_W = 20;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_SERVO_WIDTH = 8'h04;
    localparam logic [7:0] OFS_RAPID_WIDTH = 8'h08;
    localparam logic [7:0] OFS_CUT_WIDTH = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_AXIS_BASE = 8'h40;
    localparam logic [7:0] OFS_AXIS_STRIDE = 8'h08;
    localparam logic [7:0] OFS_AXIS_CUT = 8'h04;

    // Configuration register fields
    localparam int unsigned CFG_SCHEME_BIT = 0;
    localparam int unsigned CFG_RAPID_METHOD_BIT = 1;
    localparam int unsigned CFG_REV_RAPID_BIT = 3;
    localparam int unsigned CFG_REV_CUT_BIT = 4;
    localparam int unsigned CFG_AUX_LSB = 8;
    localparam int unsigned AUX_CUT_BIT = 1;
    localparam logic [31:0] CFG_MASK = 32'h0000FF1B;

    // Per-axis register fields: time constant low, mode above it
    localparam int unsigned AX_TC_LSB = 0;
    localparam int unsigned AX_MODE_LSB = 16;
    localparam logic [31:0] AX_MASK = 32'h0003FFFF;

    // Status register fields
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_HOLD_BIT = 3;
    localparam int unsigned ST_METHOD_LSB = 4;
    localparam int unsigned ST_JOINTS_LSB = 16;

    // Reset values
    localparam logic [31:0] CONFIG_RST = 32'h00000000;
    localparam logic [WIDTH_W-1:0] SERVO_WIDTH_RST = 16'h0032;
    localparam logic [WIDTH_W-1:0] BLK_WIDTH_RST = 16'h0000;
    localparam logic [31:0] AXIS_RST = 32'h00000000;

    // Scheme and method selector values
    localparam logic SCHEME_ONE = 1'b0;
    localparam logic SCHEME_TWO = 1'b1;
    localparam logic METHOD_CMD = 1'b0;
    localparam logic METHOD_INPOS = 1'b1;

    // Time constants are given in milliseconds
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned TC_UNIT_NS = 1000000;
    localparam int unsigned TICK_CYCLES = (TC_UNIT_NS + CLK_NS - 1) / CLK_NS;
    // Exponential deceleration is taken as settled after this many time constants
    localparam int unsigned EXP_DECEL_MULT = 4;

    typedef enum logic [1:0] {
        BJDC_ACC_LINEAR = 2'h0,
        BJDC_ACC_EXP = 2'h1,
        BJDC_ACC_EXP_LIN = 2'h2
    } bjdc_acc_mode_t;

    typedef enum logic [1:0] {
        BJDC_CHK_NONE = 2'h0,
        BJDC_CHK_CMD = 2'h1,
        BJDC_CHK_INPOS = 2'h2
    } bjdc_check_t;

    typedef enum logic [2:0] {
        BJDC_ST_IDLE = 3'h1,
        BJDC_ST_DECEL = 3'h2,
        BJDC_ST_INPOS = 3'h4
    } bjdc_state_t;

    // One motion block as the sequencer describes it
    typedef struct packed {
        logic rapid;
        logic exact_stop;
        logic [NUM_AXES-1:0] active;
        logic [NUM_AXES-1:0] negative;
    } bjdc_blk_t;

endpackage

// file: design/bjdc_top.sv
// Block-joint deceleration check: decision, command wait and in-position wait
//
// Overview of operation
// - Rapid traverse joints are always checked
// - Cutting joints checked on error-detect, G09 or G61
// - Selector picks scheme one or scheme two
// - Scheme one: rapid method bit picks check
// - Scheme one: cut option bit picks G1 check
// - Scheme two: rapid bit governs G0, G1+G9
// - Command check waits for command-side deceleration end
// - Wait length from mode and time constant
// - Rapid wait is longest over commanded axes
// - Cutting wait is longest over commanded axes
// - In-position: command wait, then error below width
// - Width is larger of servo and block width
// - Reversal check only when some axis reverses
// - G1 to G0 reversal uses rapid reversal flag
// - G1 to G1 reversal uses cut reversal flag
// - Zero block width leaves servo width alone
// - Rapid reversal flag: 0 off, 1 on
// - Cut reversal flag: 0 off, 1 on
// - Error-detect switch forces in-position check
`timescale 1ns/1ns
module bjdc_top #(
    parameter int unsigned TICK_CYCLES = bjdc_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic blk_end,
    input wire bjdc_pkg::bjdc_blk_t cur_blk,
    input wire bjdc_pkg::bjdc_blk_t nxt_blk,
    input wire logic error_detect_sw,
    input wire logic exact_stop_mode,
    input wire logic [bjdc_pkg::NUM_AXES-1:0][bjdc_pkg::WIDTH_W-1:0] posn_err,
    output logic blk_hold,
    output bjdc_pkg::bjdc_check_t check_kind
);

    localparam int unsigned NA = bjdc_pkg::NUM_AXES;
    localparam int unsigned WW = bjdc_pkg::WIDTH_W;
    localparam int unsigned DW = bjdc_pkg::DUR_W;

    logic [31:0] config_q;
    logic [WW-1:0] servo_width_q;
    logic [WW-1:0] rapid_width_q;
    logic [WW-1:0] cut_width_q;
    logic [NA-1:0][31:0] axis_rapid_q;
    logic [NA-1:0][31:0] axis_cut_q;
    logic [NA-1:0][DW-1:0] axis_ticks;
    bjdc_pkg::bjdc_state_t state_q;
    bjdc_pkg::bjdc_check_t method_d;
    bjdc_pkg::bjdc_check_t method_q;
    bjdc_pkg::bjdc_blk_t blk_q;
    logic [DW-1:0] dur_d;
    logic [DW-1:0] cnt_q;
    logic [31:0] div_q;
    logic tick;
    logic [15:0] joints_q;
    logic reversal;
    logic rev_check;
    logic exact;
    logic [WW-1:0] blk_width;
    logic [WW-1:0] eff_width;
    logic all_in;
    logic take;

    logic scheme;
    logic rapid_method;
    logic cut_option;
    logic rev_to_rapid;
    logic rev_to_cut;

    // Configuration fields
    assign scheme = config_q[bjdc_pkg::CFG_SCHEME_BIT];
    assign rapid_method = config_q[bjdc_pkg::CFG_RAPID_METHOD_BIT];
    assign cut_option = config_q[bjdc_pkg::CFG_AUX_LSB + bjdc_pkg::AUX_CUT_BIT];
    assign rev_to_rapid = config_q[bjdc_pkg::CFG_REV_RAPID_BIT];
    assign rev_to_cut = config_q[bjdc_pkg::CFG_REV_CUT_BIT];

    // Shared register writes; reserved bits are masked so they read zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            config_q <= bjdc_pkg::CONFIG_RST;
            servo_width_q <= bjdc_pkg::SERVO_WIDTH_RST;
            rapid_width_q <= bjdc_pkg::BLK_WIDTH_RST;
            cut_width_q <= bjdc_pkg::BLK_WIDTH_RST;
        end else if (reg_wr) begin
            if (reg_addr == bjdc_pkg::OFS_CONFIG) begin
                config_q <= reg_wdata & bjdc_pkg::CFG_MASK;
            end else if (reg_addr == bjdc_pkg::OFS_SERVO_WIDTH) begin
                servo_width_q <= reg_wdata[WW-1:0];
            end else if (reg_addr == bjdc_pkg::OFS_RAPID_WIDTH) begin
                rapid_width_q <= reg_wdata[WW-1:0];
            end else if (reg_addr == bjdc_pkg::OFS_CUT_WIDTH) begin
                cut_width_q <= reg_wdata[WW-1:0];
            end
        end
    end

    // Per-axis mode and time constant, one pair of words for each axis
    genvar gi;
    generate
        for (gi = 0; gi < NA; gi++) begin : g_axis
            localparam logic [7:0] OFS_R = 8'(bjdc_pkg::OFS_AXIS_BASE + gi * 8);
            localparam logic [7:0] OFS_C = 8'(OFS_R + bjdc_pkg::OFS_AXIS_CUT);
            logic [31:0] sel;

            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    axis_rapid_q[gi] <= bjdc_pkg::AXIS_RST;
                    axis_cut_q[gi] <= bjdc_pkg::AXIS_RST;
                end else if (reg_wr) begin
                    if (reg_addr == OFS_R) begin
                        axis_rapid_q[gi] <= reg_wdata & bjdc_pkg::AX_MASK;
                    end else if (reg_addr == OFS_C) begin
                        axis_cut_q[gi] <= reg_wdata & bjdc_pkg::AX_MASK;
                    end
                end
            end

            // Rapid blocks use rapid settings, cutting blocks the cutting ones
            assign sel = cur_blk.rapid ? axis_rapid_q[gi] : axis_cut_q[gi];

            bjdc_axis_time u_time (
                .mode(sel[bjdc_pkg::AX_MODE_LSB +: 2]),
                .time_const(sel[bjdc_pkg::AX_TC_LSB +: bjdc_pkg::TC_W]),
                .ticks(axis_ticks[gi])
            );
        end
    endgenerate

    // Longest wait among the axes commanded in the finished block
    always_comb begin
        dur_d = '0;
        for (int i = 0; i < NA; i++) begin
            if (cur_blk.active[i] && axis_ticks[i] > dur_d) begin
                dur_d = axis_ticks[i];
            end
        end
    end

    // Direction reversal of any axis moving in both blocks
    always_comb begin
        reversal = 1'b0;
        for (int i = 0; i < NA; i++) begin
            if (cur_blk.active[i] && nxt_blk.active[i] &&
                cur_blk.negative[i] != nxt_blk.negative[i]) begin
                reversal = 1'b1;
            end
        end
    end

    // Reversal check is only offered after a cutting block
    assign rev_check = !cur_blk.rapid && reversal &&
                       (nxt_blk.rapid ? rev_to_rapid : rev_to_cut);
    assign exact = cur_blk.exact_stop || exact_stop_mode;

    // Joint decision; error-detect has the last word
    always_comb begin
        method_d = bjdc_pkg::BJDC_CHK_NONE;
        if (cur_blk.rapid) begin
            // Rapid joints are never skipped
            method_d = (rapid_method == bjdc_pkg::METHOD_INPOS) ?
                       bjdc_pkg::BJDC_CHK_INPOS : bjdc_pkg::BJDC_CHK_CMD;
        end else if (scheme == bjdc_pkg::SCHEME_ONE) begin
            if (exact) begin
                method_d = cut_option ?
                           bjdc_pkg::BJDC_CHK_INPOS : bjdc_pkg::BJDC_CHK_CMD;
            end else if (cut_option) begin
                method_d = bjdc_pkg::BJDC_CHK_INPOS;
            end
        end else if (exact) begin
            // Plain G1 under scheme two stays unchecked unless a reversal check or error-detect applies
            method_d = (rapid_method == bjdc_pkg::METHOD_INPOS) ?
                       bjdc_pkg::BJDC_CHK_INPOS : bjdc_pkg::BJDC_CHK_CMD;
        end
        if (rev_check && method_d == bjdc_pkg::BJDC_CHK_NONE) begin
            method_d = bjdc_pkg::BJDC_CHK_CMD;
        end
        if (error_detect_sw) begin
            method_d = bjdc_pkg::BJDC_CHK_INPOS;
        end
    end

    // A joint is taken only while idle; the sequencer waits on the hold
    assign take = blk_end && state_q == bjdc_pkg::BJDC_ST_IDLE &&
                  method_d != bjdc_pkg::BJDC_CHK_NONE;
    assign blk_hold = take || state_q != bjdc_pkg::BJDC_ST_IDLE;

    // Millisecond enable; restarted at each joint so the first tick is a full one
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
        end else if (state_q != bjdc_pkg::BJDC_ST_DECEL || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 32'h00000001;
        end
    end
    assign tick = div_q == 32'(TICK_CYCLES - 1);

    // In-position width: block width counts only when set
    assign blk_width = blk_q.rapid ? rapid_width_q : cut_width_q;
    assign eff_width = (blk_width == '0 || blk_width < servo_width_q) ?
                       servo_width_q : blk_width;

    // Every axis of the finished block must have settled
    always_comb begin
        all_in = 1'b1;
        for (int i = 0; i < NA; i++) begin
            if (blk_q.active[i] && posn_err[i] >= eff_width) begin
                all_in = 1'b0;
            end
        end
    end

    // Joint sequencing
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= bjdc_pkg::BJDC_ST_IDLE;
            cnt_q <= '0;
            method_q <= bjdc_pkg::BJDC_CHK_NONE;
            blk_q <= '0;
        end else begin
            case (state_q)
                bjdc_pkg::BJDC_ST_IDLE: begin
                    if (take) begin
                        state_q <= bjdc_pkg::BJDC_ST_DECEL;
                        cnt_q <= dur_d;
                        method_q <= method_d;
                        blk_q <= cur_blk;
                    end
                end
                bjdc_pkg::BJDC_ST_DECEL: begin
                    if (cnt_q == '0) begin
                        // In-position always follows a full command wait
                        state_q <= (method_q == bjdc_pkg::BJDC_CHK_INPOS) ?
                                   bjdc_pkg::BJDC_ST_INPOS : bjdc_pkg::BJDC_ST_IDLE;
                    end else if (tick) begin
                        cnt_q <= cnt_q - DW'(1);
                    end
                end
                bjdc_pkg::BJDC_ST_INPOS: begin
                    if (all_in) begin
                        state_q <= bjdc_pkg::BJDC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= bjdc_pkg::BJDC_ST_IDLE;
                end
            endcase
        end
    end

    // Count of checked joints, wraps
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            joints_q <= 16'h0000;
        end else if (take) begin
            joints_q <= joints_q + 16'h0001;
        end
    end

    // Kind of the running check, none while idle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            check_kind <= bjdc_pkg::BJDC_CHK_NONE;
        end else if (take) begin
            check_kind <= method_d;
        end else if (state_q == bjdc_pkg::BJDC_ST_IDLE ||
                     (state_q == bjdc_pkg::BJDC_ST_INPOS && all_in) ||
                     (state_q == bjdc_pkg::BJDC_ST_DECEL && cnt_q == '0 &&
                      method_q != bjdc_pkg::BJDC_CHK_INPOS)) begin
            check_kind <= bjdc_pkg::BJDC_CHK_NONE;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                if (reg_addr == bjdc_pkg::OFS_CONFIG) begin
                    reg_rdata <= config_q;
                end else if (reg_addr == bjdc_pkg::OFS_SERVO_WIDTH) begin
                    reg_rdata <= 32'(servo_width_q);
                end else if (reg_addr == bjdc_pkg::OFS_RAPID_WIDTH) begin
                    reg_rdata <= 32'(rapid_width_q);
                end else if (reg_addr == bjdc_pkg::OFS_CUT_WIDTH) begin
                    reg_rdata <= 32'(cut_width_q);
                end else if (reg_addr == bjdc_pkg::OFS_STATUS) begin
                    reg_rdata[bjdc_pkg::ST_STATE_LSB +: 3] <= state_q;
                    reg_rdata[bjdc_pkg::ST_HOLD_BIT] <= blk_hold;
                    reg_rdata[bjdc_pkg::ST_METHOD_LSB +: 2] <= method_q;
                    reg_rdata[bjdc_pkg::ST_JOINTS_LSB +: 16] <= joints_q;
                end else begin
                    // Axis words; unmapped addresses read zero
                    for (int i = 0; i < NA; i++) begin
                        if (reg_addr == 8'(bjdc_pkg::OFS_AXIS_BASE + i * 8)) begin
                            reg_rdata <= axis_rapid_q[i];
                        end else if (reg_addr == 8'(bjdc_pkg::OFS_AXIS_BASE + i * 8 +
                                                    bjdc_pkg::OFS_AXIS_CUT)) begin
                            reg_rdata <= axis_cut_q[i];
                        end
                    end
                end
            end
        end
    end

endmodule

// file: tb/bjdc_properties.sv
// Checker for the block-joint deceleration check ports
`timescale 1ns/1ns
module bjdc_properties #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic blk_end,
    input wire bjdc_pkg::bjdc_blk_t cur_blk,
    input wire bjdc_pkg::bjdc_blk_t nxt_blk,
    input wire logic error_detect_sw,
    input wire logic exact_stop_mode,
    input wire logic [bjdc_pkg::NUM_AXES-1:0][bjdc_pkg::WIDTH_W-1:0] posn_err,
    input wire logic blk_hold,
    input wire bjdc_pkg::bjdc_check_t check_kind
);
    logic [15:0] cfg_q;
    logic rev;
    logic flag;
    logic plain;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Shadow of the config word, so that decisions can be predicted here
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= 16'h0000;
        end else if (reg_wr && reg_addr == bjdc_pkg::OFS_CONFIG) begin
            cfg_q <= reg_wdata[15:0] & bjdc_pkg::CFG_MASK[15:0];
        end
    end
    // Reversal counts only on an axis that moves in both blocks
    assign rev = |(cur_blk.active & nxt_blk.active & (cur_blk.negative ^ nxt_blk.negative));
    assign flag = nxt_blk.rapid ? cfg_q[3] : cfg_q[4];
    assign plain = !cur_blk.rapid && !cur_blk.exact_stop && !exact_stop_mode && !error_detect_sw;
    sequence s_take;
        blk_end && check_kind == bjdc_pkg::BJDC_CHK_NONE;
    endsequence
    sequence s_busy2;
        check_kind != bjdc_pkg::BJDC_CHK_NONE ##1 check_kind != bjdc_pkg::BJDC_CHK_NONE;
    endsequence
    a_rapid_always: assert property (s_take ##0 cur_blk.rapid |-> blk_hold)
        else $error("rapid joint not held");
    a_rapid_method: assert property (s_take ##0 (cur_blk.rapid && !error_detect_sw) |=>
        check_kind == (cfg_q[1] ? bjdc_pkg::BJDC_CHK_INPOS : bjdc_pkg::BJDC_CHK_CMD))
        else $error("rapid check method wrong");
    a_cut_scheme_one: assert property (s_take ##0 (!cur_blk.rapid && !error_detect_sw &&
        (cur_blk.exact_stop || exact_stop_mode) && !cfg_q[0]) |=>
        check_kind == (cfg_q[9] ? bjdc_pkg::BJDC_CHK_INPOS : bjdc_pkg::BJDC_CHK_CMD))
        else $error("scheme one exact stop method wrong");
    a_cut_scheme_two: assert property (s_take ##0 (!cur_blk.rapid && !error_detect_sw &&
        (cur_blk.exact_stop || exact_stop_mode) && cfg_q[0]) |=>
        check_kind == (cfg_q[1] ? bjdc_pkg::BJDC_CHK_INPOS : bjdc_pkg::BJDC_CHK_CMD))
        else $error("scheme two exact stop method wrong");
    a_plain_cut_free: assert property (s_take ##0 (plain && !(rev && flag) &&
        (cfg_q[0] || !cfg_q[9])) |-> !blk_hold)
        else $error("plain cutting joint held");
    a_reversal_held: assert property (s_take ##0 (!cur_blk.rapid && rev && flag) |-> blk_hold)
        else $error("reversal joint not held");
    a_error_detect: assert property (s_take ##0 error_detect_sw |=>
        check_kind == bjdc_pkg::BJDC_CHK_INPOS)
        else $error("error detect did not force in-position");
    a_hold_check: assert property (check_kind != bjdc_pkg::BJDC_CHK_NONE |-> blk_hold)
        else $error("hold low during check");
    a_idle_free: assert property (check_kind == bjdc_pkg::BJDC_CHK_NONE && !blk_end |-> !blk_hold)
        else $error("hold high while idle");
    a_kind_stable: assert property (s_busy2 |-> $stable(check_kind))
        else $error("check kind changed mid check");
    a_read_gap: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside read slot");
endmodule

bind bjdc_top bjdc_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .blk_end(blk_end),
    .cur_blk(cur_blk), .nxt_blk(nxt_blk), .error_detect_sw(error_detect_sw),
    .exact_stop_mode(exact_stop_mode), .posn_err(posn_err), .blk_hold(blk_hold),
    .check_kind(check_kind)
);

// file: tb/bjdc_servo_model.sv
// Servo axis model: positional error that settles after a move
`timescale 1ns/1ns
module bjdc_servo_model #(
    parameter int unsigned STEP = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [15:0] load_err,
    output logic [bjdc_pkg::NUM_AXES-1:0][bjdc_pkg::WIDTH_W-1:0] posn_err
);
    logic [15:0] err_q;
    // Error shrinks one step a cycle, never faster, as a real loop lags
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            err_q <= 16'h0000;
        end else if (load) begin
            err_q <= load_err;
        end else if (err_q > 16'(STEP)) begin
            err_q <= err_q - 16'(STEP);
        end else begin
            err_q <= 16'h0000;
        end
    end
    // All axes share one lag; per-axis spread is not modelled
    always_comb begin
        for (int i = 0; i < bjdc_pkg::NUM_AXES; i++) begin
            posn_err[i] = err_q;
        end
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the block-joint deceleration check
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic [15:0] cfg;
        bjdc_pkg::bjdc_blk_t cur;
        bjdc_pkg::bjdc_blk_t nxt;
        logic eds;
        logic g61;
        bjdc_pkg::bjdc_check_t want;
    } bjdc_row_t;
    localparam int unsigned TICKS = 4;
    localparam bjdc_pkg::bjdc_check_t NO = bjdc_pkg::BJDC_CHK_NONE;
    localparam bjdc_pkg::bjdc_check_t CM = bjdc_pkg::BJDC_CHK_CMD;
    localparam bjdc_pkg::bjdc_check_t IP = bjdc_pkg::BJDC_CHK_INPOS;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic blk_end = 1'b0;
    bjdc_pkg::bjdc_blk_t cur_blk = '0;
    bjdc_pkg::bjdc_blk_t nxt_blk = '0;
    logic error_detect_sw = 1'b0;
    logic exact_stop_mode = 1'b0;
    logic [bjdc_pkg::NUM_AXES-1:0][bjdc_pkg::WIDTH_W-1:0] posn_err;
    logic blk_hold;
    bjdc_pkg::bjdc_check_t check_kind;
    logic ld = 1'b0;
    logic [15:0] ld_err = 16'h0;
    bjdc_row_t rows [17];
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int joints = 0;
    int n;
    logic [31:0] rd_v;
    bjdc_top #(.TICK_CYCLES(TICKS)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .blk_end(blk_end), .cur_blk(cur_blk), .nxt_blk(nxt_blk),
        .error_detect_sw(error_detect_sw), .exact_stop_mode(exact_stop_mode),
        .posn_err(posn_err), .blk_hold(blk_hold), .check_kind(check_kind));
    bjdc_servo_model u_servo (.mclk(mclk), .sys_rst(sys_rst), .load(ld),
        .load_err(ld_err), .posn_err(posn_err));
    initial begin
        forever #4 mclk = ~mclk;
    end
    // Cut a hang short well past the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read data is taken only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
        cmp(rd_v, want);
    endtask
    // One joint; the next block waits until hold drops
    task automatic joint(input bjdc_pkg::bjdc_check_t want, output int len);
        @(posedge mclk);
        blk_end <= 1'b1;
        #1;
        cmp(blk_hold, want != NO);
        @(posedge mclk);
        blk_end <= 1'b0;
        #1;
        cmp(check_kind, want);
        len = 1;
        while (blk_hold === 1'b1 && len < 400) begin
            @(posedge mclk);
            #1;
            len++;
        end
        if (want != NO) joints++;
    endtask
    // Servo error starts at 0x40 and the wait must end near the width crossing
    task automatic inpos_run(input int lo, input int hi);
        @(posedge mclk);
        ld <= 1'b1;
        ld_err <= 16'h0040;
        @(posedge mclk);
        ld <= 1'b0;
        joint(IP, n);
        cmp(n >= lo && n <= hi, 1'b1);
    endtask
    initial begin
        rows[0] = {16'h0000, 10'h210, 10'h010, 2'b00, CM};
        rows[1] = {16'h0002, 10'h210, 10'h010, 2'b00, IP};
        rows[2] = {16'h0000, 10'h010, 10'h010, 2'b00, NO};
        rows[3] = {16'h0200, 10'h010, 10'h010, 2'b00, IP};
        rows[4] = {16'h0000, 10'h110, 10'h010, 2'b00, CM};
        rows[5] = {16'h0200, 10'h110, 10'h010, 2'b00, IP};
        rows[6] = {16'h0000, 10'h010, 10'h010, 2'b01, CM};
        rows[7] = {16'h0001, 10'h110, 10'h010, 2'b00, CM};
        rows[8] = {16'h0003, 10'h110, 10'h010, 2'b00, IP};
        rows[9] = {16'h0201, 10'h010, 10'h010, 2'b00, NO};
        rows[10] = {16'h0003, 10'h210, 10'h010, 2'b00, IP};
        rows[11] = {16'h0000, 10'h010, 10'h010, 2'b10, IP};
        rows[12] = {16'h0008, 10'h010, 10'h211, 2'b00, CM};
        rows[13] = {16'h0010, 10'h010, 10'h211, 2'b00, NO};
        rows[14] = {16'h0010, 10'h010, 10'h011, 2'b00, CM};
        rows[15] = {16'h0008, 10'h010, 10'h011, 2'b00, NO};
        rows[16] = {16'h0018, 10'h010, 10'h010, 2'b00, NO};
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(bjdc_pkg::OFS_CONFIG, 32'h00000000);
        rdc(bjdc_pkg::OFS_SERVO_WIDTH, 32'h00000032);
        rdc(bjdc_pkg::OFS_RAPID_WIDTH, 32'h00000000);
        rdc(bjdc_pkg::OFS_CUT_WIDTH, 32'h00000000);
        rdc(8'h4C, 32'h00000000);
        rdc(8'h20, 32'h00000000);
        wr(bjdc_pkg::OFS_STATUS, 32'hFFFFFFFF);
        rdc(bjdc_pkg::OFS_STATUS, 32'h00000001);
        wr(bjdc_pkg::OFS_CONFIG, 32'hFFFFFFFF);
        rdc(bjdc_pkg::OFS_CONFIG, 32'h0000FF1B);
        // Decision table: every scheme, method, option and reversal flag
        for (int k = 0; k < 17; k++) begin
            wr(bjdc_pkg::OFS_CONFIG, {16'h0000, rows[k].cfg});
            cur_blk <= rows[k].cur;
            nxt_blk <= rows[k].nxt;
            error_detect_sw <= rows[k].eds;
            exact_stop_mode <= rows[k].g61;
            joint(rows[k].want, n);
        end
        // In-position width: servo alone, block width larger, block width smaller
        wr(bjdc_pkg::OFS_CONFIG, 32'h00000002);
        error_detect_sw <= 1'b0;
        cur_blk <= 10'h210;
        nxt_blk <= 10'h010;
        inpos_run(13, 18);
        wr(bjdc_pkg::OFS_RAPID_WIDTH, 32'h00000050);
        inpos_run(2, 5);
        wr(bjdc_pkg::OFS_RAPID_WIDTH, 32'h00000020);
        inpos_run(13, 18);
        wr(bjdc_pkg::OFS_CUT_WIDTH, 32'h00000038);
        cur_blk <= 10'h010;
        error_detect_sw <= 1'b1;
        inpos_run(7, 12);
        // Command wait lengths: rapid and cutting sets, longest active axis wins
        error_detect_sw <= 1'b0;
        wr(bjdc_pkg::OFS_CONFIG, 32'h00000000);
        wr(8'h40, 32'h00000002);
        wr(8'h48, 32'h00010001);
        wr(8'h44, 32'h00030005);
        wr(8'h4C, 32'h00020003);
        for (int k = 0; k < 4; k++) begin
            cur_blk <= k == 0 ? 10'h210 : k == 1 ? 10'h230 : k == 2 ? 10'h120 : 10'h130;
            joint(CM, n);
            cmp(n, (k == 0 ? 2 : k == 1 ? 4 : k == 2 ? 3 : 5) * TICKS + 2);
        end
        rdc(bjdc_pkg::OFS_STATUS, {joints[15:0], 16'h0011});
        cmp(rd_v[31:16], joints[15:0]);
        cmp(rd_v[2:0], 3'h1);
        // Reset in the middle of a long check drops everything at once
        cur_blk <= 10'h210;
        @(posedge mclk);
        blk_end <= 1'b1;
        @(posedge mclk);
        blk_end <= 1'b0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b1;
        #1;
        cmp(blk_hold, 1'b0);
        cmp(check_kind, NO);
        @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(8'h40, 32'h00000000);
        rdc(bjdc_pkg::OFS_STATUS, 32'h00000001);
        close_out();
    end
endmodule
